// *** sev_params.svh ***
// Constants for the serial EEPROM read-path ends
`ifndef SEV_PARAMS_SVH
`define SEV_PARAMS_SVH

// ==========================================================
// Memory and addressing
`define SEV_MEM_AW          13
// Arbitrary neutral type code, not a real part value
`define SEV_TYPE_CODE       4'h5
`define SEV_RW_READ         1'b1
`define SEV_RW_WRITE        1'b0
`define SEV_BIT_ACK         4'h8

// ==========================================================
// Timing
`define SEV_CLK_PERIOD_NS   5
`define SEV_SCL_PERIOD_NS   2500
`define SEV_QUARTER_CYC     ((`SEV_SCL_PERIOD_NS + 4*`SEV_CLK_PERIOD_NS - 1) / (4*`SEV_CLK_PERIOD_NS))

// ==========================================================
// Buffering
`define SEV_FIFO_DEPTH      8
`define SEV_FIFO_WIDTH      8

`endif

// *** sev_pkg.sv ***
// Types shared by both ends of the serial EEPROM link
package sev_pkg;

    // ==========================================================
    // Target end
    typedef enum logic [2:0] {
        D_IDLE,
        D_RX,
        D_ACK,
        D_TX,
        D_HACK
    } sev_dst_e;

    typedef enum logic [1:0] {
        K_DEV,
        K_AHI,
        K_ALO,
        K_DATA
    } sev_kind_e;

    // ==========================================================
    // Controller end
    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_WBYTE,
        H_RBYTE,
        H_STOP
    } sev_hst_e;

endpackage : sev_pkg

// *** sev_i2c_if.sv ***
// Two-wire bus carrier with open-drain data resolution
`timescale 1ns/10ps
`default_nettype none

interface sev_i2c_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Pull-up: line is low only while an enabled driver pulls it low
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : sev_i2c_if

`default_nettype wire

// *** sev_dev_end.sv ***
// Serial EEPROM target end: read path with internal address counter
`timescale 1ns/10ps
`default_nettype none
`include "sev_params.svh"

module sev_dev_end
    import sev_pkg::*;
#(
    parameter int         AW        = `SEV_MEM_AW,
    parameter logic [3:0] TYPE_CODE = `SEV_TYPE_CODE
) (
    input  wire logic          i_link_clk,
    input  wire logic          i_link_rst,
    input  wire logic          i_select_pin_bit0,
    input  wire logic          i_select_pin_bit1,
    input  wire logic          i_select_pin_bit2,
    input  wire logic          i_wr_busy,
    input  wire logic          i_ld_en,
    input  wire logic [AW-1:0] i_ld_addr,
    input  wire logic [7:0]    i_ld_data,
    output logic      [AW-1:0] o_cur_addr,
    output logic               o_byte_sent,
    sev_i2c_if.dev             bus
);

    // ==========================================================
    // Pin synchronisers
    // Stage 0 feeds stage 1 only; stage 2 is a delayed copy for edges
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic [2:0] sel_meta_reg;
    logic [2:0] sel_sync_reg;

    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            sel_meta_reg <= 3'h0;
            sel_sync_reg <= 3'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
            sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
            sel_meta_reg <= {i_select_pin_bit2, i_select_pin_bit1, i_select_pin_bit0};
            sel_sync_reg <= sel_meta_reg;
        end
    end

    logic scl_s;
    logic scl_d;
    logic sda_s;
    logic sda_d;
    assign scl_s = scl_sync_reg[1];
    assign scl_d = scl_sync_reg[2];
    assign sda_s = sda_sync_reg[1];
    assign sda_d = sda_sync_reg[2];

    logic scl_rise;
    logic scl_fall;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;

    logic start_det;
    logic stop_det;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

    // ==========================================================
    // Memory array, filled from the user side
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_link_clk) begin
        if (i_ld_en) begin
            mem[i_ld_addr] <= i_ld_data;
        end
    end

    // ==========================================================
    // Protocol state
    sev_dst_e  st_reg,   st_next;
    sev_kind_e kind_reg, kind_next;
    logic          rw_reg,   rw_next;
    logic          hack_reg, hack_next;
    logic          oe_reg,   oe_next;
    logic [3:0]    cnt_reg,  cnt_next;
    logic [7:0]    sh_reg,   sh_next;
    logic [7:0]    ahi_reg,  ahi_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic          sent_reg;

    logic [7:0]    rd_byte;
    logic [AW-1:0] addr_inc;
    logic [15:0]   addr_full;
    logic          byte_done;
    logic          dev_match;
    logic          rx_ack;
    logic          load_tx;

    assign rd_byte   = mem[addr_reg];
    // natural wrap at the top of memory
    assign addr_inc  = addr_reg + 1'b1;
    assign addr_full = {ahi_reg, sh_reg};
    // eight data bits are in, ninth clock is the ack slot
    assign byte_done = scl_fall && (cnt_reg == `SEV_BIT_ACK);
    // type code and select pins must match
    // busy internal write hides the device
    assign dev_match = (sh_reg[7:1] == {TYPE_CODE, sel_sync_reg}) && !i_wr_busy;
    // Write data bytes are not acked: the write path is not part of this end
    assign rx_ack    = (kind_reg == K_DEV) ? dev_match : (kind_reg != K_DATA);
    // read address acked, controller ack asks for more
    assign load_tx   = scl_fall && (((st_reg == D_ACK) && (kind_reg == K_DEV) && rw_reg)
                                   || ((st_reg == D_HACK) && hack_reg));

    always_comb begin
        st_next   = st_reg;
        kind_next = kind_reg;
        rw_next   = rw_reg;
        hack_next = hack_reg;
        oe_next   = oe_reg;
        cnt_next  = cnt_reg;
        sh_next   = sh_reg;
        ahi_next  = ahi_reg;
        addr_next = addr_reg;
        if (start_det) begin
            // Repeated start lands here too and re-opens address phase
            st_next   = D_RX;
            kind_next = K_DEV;
            cnt_next  = 4'h0;
            oe_next   = 1'b0;
        end else if (stop_det) begin
            st_next = D_IDLE;
            oe_next = 1'b0;
        end else if (load_tx) begin
            // pointer moves past every byte handed out
            st_next   = D_TX;
            sh_next   = rd_byte;
            oe_next   = ~rd_byte[7];
            addr_next = addr_inc;
            cnt_next  = 4'h0;
        end else begin
            unique case (st_reg)
                D_IDLE: begin
                end
                D_RX: begin
                    if (scl_rise) begin
                        sh_next  = {sh_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        if (rx_ack) begin
                            st_next = D_ACK;
                            oe_next = 1'b1;
                        end else begin
                            st_next = D_IDLE;
                        end
                        if (kind_reg == K_DEV) begin
                            rw_next = sh_reg[0];
                        end
                        // two address bytes into the pointer
                        if (kind_reg == K_AHI) begin
                            ahi_next = sh_reg;
                        end
                        if (kind_reg == K_ALO) begin
                            addr_next = addr_full[AW-1:0];
                        end
                    end
                end
                D_ACK: begin
                    if (scl_fall) begin
                        st_next  = D_RX;
                        oe_next  = 1'b0;
                        cnt_next = 4'h0;
                        unique case (kind_reg)
                            K_DEV:   kind_next = K_AHI;
                            K_AHI:   kind_next = K_ALO;
                            K_ALO:   kind_next = K_DATA;
                            K_DATA:  kind_next = K_DATA;
                        endcase
                    end
                end
                D_TX: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == `SEV_BIT_ACK) begin
                            // let go for the controller's answer
                            st_next = D_HACK;
                            oe_next = 1'b0;
                        end else begin
                            // next bit only after the fall
                            oe_next = ~sh_reg[6];
                            sh_next = {sh_reg[6:0], 1'b0};
                        end
                    end
                end
                D_HACK: begin
                    if (scl_rise) begin
                        hack_next = ~sda_s;
                    end else if (scl_fall) begin
                        // nack ends driving until the next start
                        st_next = D_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            st_reg   <= D_IDLE;
            kind_reg <= K_DEV;
            rw_reg   <= 1'b0;
            hack_reg <= 1'b0;
            oe_reg   <= 1'b0;
            cnt_reg  <= 4'h0;
            sh_reg   <= 8'h00;
            ahi_reg  <= 8'h00;
            addr_reg <= '0;
            sent_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            kind_reg <= kind_next;
            rw_reg   <= rw_next;
            hack_reg <= hack_next;
            oe_reg   <= oe_next;
            cnt_reg  <= cnt_next;
            sh_reg   <= sh_next;
            ahi_reg  <= ahi_next;
            addr_reg <= addr_next;
            sent_reg <= load_tx;
        end
    end

    // ==========================================================
    // Outputs
    // open-drain: only ever pulls low
    assign bus.dev_sda_o  = 1'b0;
    assign bus.dev_sda_oe = oe_reg;
    assign o_cur_addr     = addr_reg;
    assign o_byte_sent    = sent_reg;

endmodule : sev_dev_end

`default_nettype wire

// *** sev_host_end.sv ***
// Two-wire bus controller end issuing reads, with read-data FIFO
`timescale 1ns/10ps
`default_nettype none
`include "sev_params.svh"

// ==========================================================
// FIFO; depth must be a power of two
module sev_fifo #(
    parameter int W = `SEV_FIFO_WIDTH,
    parameter int D = `SEV_FIFO_DEPTH
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic      [W-1:0] o_out_data
);
    localparam int PW = $clog2(D);

    logic [W-1:0] mem [0:D-1];
    logic [PW:0]  wr_reg;
    logic [PW:0]  rd_reg;
    logic         full;
    logic         empty;

    assign full        = (wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
    assign empty       = (wr_reg == rd_reg);
    assign o_in_ready  = ~full;
    assign o_out_valid = ~empty;
    assign o_out_data  = mem[rd_reg[PW-1:0]];

    always_ff @(posedge i_clk) begin
        if (i_in_valid && !full) begin
            mem[wr_reg[PW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_reg + {{PW{1'b0}}, (i_in_valid && !full)};
            rd_reg <= rd_reg + {{PW{1'b0}}, (i_out_ready && !empty)};
        end
    end
endmodule : sev_fifo

// ==========================================================
// Controller end
module sev_host_end
    import sev_pkg::*;
#(
    parameter int         QUARTER   = `SEV_QUARTER_CYC,
    parameter logic [3:0] TYPE_CODE = `SEV_TYPE_CODE
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire logic        i_cmd_selective,
    input  wire logic [15:0] i_cmd_addr,
    input  wire logic [7:0]  i_cmd_len,
    input  wire logic [2:0]  i_cmd_select,
    output logic             o_rd_valid,
    input  wire logic        i_rd_ready,
    output logic      [7:0]  o_rd_data,
    output logic             o_nack,
    output logic             o_done,
    sev_i2c_if.host          bus
);
    logic [1:0] sda_sync_reg;

    sev_hst_e    st_reg;
    logic [15:0] q_reg;
    logic [1:0]  ph_reg;
    logic [3:0]  bit_reg;
    logic [1:0]  step_reg;
    logic        rs_reg;
    logic        sel_reg;
    logic [15:0] addr_reg;
    logic [2:0]  dsel_reg;
    logic [7:0]  len_reg;
    logic [7:0]  tx_reg;
    logic [7:0]  rx_reg;
    logic        ack_reg;
    logic        pushed_reg;
    logic        scl_reg;
    logic        sda_oe_reg;
    logic        nack_reg;
    logic        done_reg;

    logic       sda_s;
    logic       q_end;
    logic       in_valid;
    logic       in_ready;
    logic       tick;
    logic       bit_end;
    logic       byte_end;
    logic       scl_lvl;
    logic       sda_lvl;
    logic       last_rd;
    logic       take_cmd;
    logic [7:0] rd_addr_byte;
    logic [7:0] wr_addr_byte;

    assign sda_s        = sda_sync_reg[1];
    assign q_end        = (q_reg == 16'(QUARTER - 1));
    assign in_valid     = (st_reg == H_RBYTE) && (bit_reg == `SEV_BIT_ACK) && !pushed_reg;
    // Full FIFO holds SCL low: back-pressure reaches the bus
    assign tick         = q_end && !(in_valid && !in_ready);
    assign bit_end      = tick && (ph_reg == 2'h3);
    assign byte_end     = bit_end && (bit_reg == `SEV_BIT_ACK);
    assign last_rd      = (len_reg == 8'h01);
    assign take_cmd     = (st_reg == H_IDLE) && i_cmd_valid;
    assign rd_addr_byte = {TYPE_CODE, dsel_reg, `SEV_RW_READ};
    assign wr_addr_byte = {TYPE_CODE, dsel_reg, `SEV_RW_WRITE};
    assign o_cmd_ready  = (st_reg == H_IDLE);

    // Pin levels per quarter; a start or stop changes SDA only with SCL high
    // First start keeps SCL high: no stray clock pulse on an idle bus
    assign scl_lvl = (st_reg == H_IDLE) || (ph_reg == 2'h1) || (ph_reg == 2'h2)
                     || ((st_reg == H_STOP) && (ph_reg == 2'h3))
                     || ((st_reg == H_START) && !rs_reg && (ph_reg == 2'h0));
    // release during ack slot of written bytes
    assign sda_lvl = (st_reg == H_IDLE)  ? 1'b1 :
                     (st_reg == H_START) ? (ph_reg < 2'h2) :
                     (st_reg == H_STOP)  ? (ph_reg >= 2'h2) :
                     (st_reg == H_WBYTE) ? ((bit_reg == `SEV_BIT_ACK) | tx_reg[7]) :
                     ((bit_reg != `SEV_BIT_ACK) | last_rd);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sda_sync_reg <= 2'h3;
            q_reg        <= 16'h0000;
            ph_reg       <= 2'h0;
            scl_reg      <= 1'b1;
            sda_oe_reg   <= 1'b0;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], bus.sda};
            q_reg        <= (take_cmd || (q_end && tick)) ? 16'h0000 :
                            (q_end ? q_reg : q_reg + 16'h0001);
            ph_reg       <= take_cmd ? 2'h0 : (tick ? ph_reg + 2'h1 : ph_reg);
            scl_reg      <= scl_lvl;
            sda_oe_reg   <= ~sda_lvl;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_reg     <= H_IDLE;
            bit_reg    <= 4'h0;
            step_reg   <= 2'h0;
            rs_reg     <= 1'b0;
            sel_reg    <= 1'b0;
            addr_reg   <= 16'h0000;
            dsel_reg   <= 3'h0;
            len_reg    <= 8'h00;
            tx_reg     <= 8'h00;
            rx_reg     <= 8'h00;
            ack_reg    <= 1'b0;
            pushed_reg <= 1'b0;
            nack_reg   <= 1'b0;
            done_reg   <= 1'b0;
        end else begin
            nack_reg <= 1'b0;
            done_reg <= 1'b0;
            if (in_valid && in_ready) begin
                pushed_reg <= 1'b1;
            end
            if (tick && (ph_reg == 2'h1)) begin
                if ((st_reg == H_RBYTE) && (bit_reg != `SEV_BIT_ACK)) begin
                    rx_reg <= {rx_reg[6:0], sda_s};
                end
                ack_reg <= ~sda_s;
            end
            if (bit_end && (st_reg == H_WBYTE || st_reg == H_RBYTE)) begin
                bit_reg <= (bit_reg == `SEV_BIT_ACK) ? 4'h0 : bit_reg + 4'h1;
                tx_reg  <= {tx_reg[6:0], 1'b1};
            end
            unique case (st_reg)
                H_IDLE: begin
                    if (i_cmd_valid) begin
                        st_reg   <= H_START;
                        sel_reg  <= i_cmd_selective;
                        addr_reg <= i_cmd_addr;
                        dsel_reg <= i_cmd_select;
                        len_reg  <= (i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
                        rs_reg   <= 1'b0;
                        bit_reg  <= 4'h0;
                    end
                end
                H_START: begin
                    if (bit_end) begin
                        // dummy write first, then read address
                        st_reg   <= H_WBYTE;
                        tx_reg   <= (sel_reg && !rs_reg) ? wr_addr_byte : rd_addr_byte;
                        step_reg <= (sel_reg && !rs_reg) ? 2'h0 : 2'h3;
                    end
                end
                H_WBYTE: begin
                    if (byte_end) begin
                        if (!ack_reg) begin
                            st_reg   <= H_STOP;
                            nack_reg <= 1'b1;
                        end else begin
                            unique case (step_reg)
                                2'h0: begin
                                    tx_reg   <= addr_reg[15:8];
                                    step_reg <= 2'h1;
                                end
                                2'h1: begin
                                    tx_reg   <= addr_reg[7:0];
                                    step_reg <= 2'h2;
                                end
                                2'h2: begin
                                    st_reg <= H_START;
                                    rs_reg <= 1'b1;
                                end
                                2'h3: st_reg <= H_RBYTE;
                            endcase
                        end
                    end
                end
                H_RBYTE: begin
                    if (byte_end) begin
                        pushed_reg <= 1'b0;
                        len_reg    <= len_reg - 8'h01;
                        st_reg     <= last_rd ? H_STOP : H_RBYTE;
                    end
                end
                H_STOP: begin
                    if (bit_end) begin
                        st_reg   <= H_IDLE;
                        done_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    sev_fifo #(
        .W (`SEV_FIFO_WIDTH),
        .D (`SEV_FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_core_clk),
        .i_rst       (i_rst),
        .i_in_valid  (in_valid),
        .o_in_ready  (in_ready),
        .i_in_data   (rx_reg),
        .o_out_valid (o_rd_valid),
        .i_out_ready (i_rd_ready),
        .o_out_data  (o_rd_data)
    );

    assign bus.scl         = scl_reg;
    assign bus.host_sda_o  = 1'b0;
    assign bus.host_sda_oe = sda_oe_reg;
    assign o_nack          = nack_reg;
    assign o_done          = done_reg;

endmodule : sev_host_end

`default_nettype wire

// *** sev_link_properties.sv ***
// Wire-level checks of the two-wire read link
`timescale 1ns/10ps
`default_nettype none
`include "sev_params.svh"
module sev_link_properties #(
    parameter logic [3:0] TYPE_CODE = `SEV_TYPE_CODE,
    parameter logic [2:0] SEL = 3'h5
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    // ==========================================================
    // Bus tracking
    logic scl_reg, sda_reg, frm_reg, rd_reg;
    logic [3:0] bit_reg;
    logic [7:0] byt_reg, sh_reg;
    wire rise = scl & ~scl_reg;
    wire start = scl & scl_reg & sda_reg & ~sda;
    wire stop = scl & scl_reg & ~sda_reg & sda;
    wire ack9 = rise & (bit_reg == 4'h8);
    wire adr = byt_reg == 8'h00;
    always_ff @(posedge i_core_clk) begin
        scl_reg <= i_rst | scl;
        sda_reg <= i_rst | sda;
        frm_reg <= !i_rst && (start || (frm_reg && !stop));
        bit_reg <= (i_rst || start || ack9) ? 4'h0 : bit_reg + {3'h0, rise};
        byt_reg <= (i_rst || start) ? 8'h00 : byt_reg + {7'h00, ack9};
        sh_reg <= rise ? {sh_reg[6:0], sda} : sh_reg;
        rd_reg <= (rise && adr && bit_reg == 4'h7) ? sda : rd_reg & !start & !i_rst;
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    AST_OPEN_DRAIN: assert property (!dev_sda_o && !host_sda_o)
        else $error("sda driven high");
    AST_DEV_EDGE: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device sda moved while scl high");
    AST_IDLE_FREE: assert property (!frm_reg |-> !dev_sda_oe && scl)
        else $error("device drives an idle bus");
    AST_ADDR_RELEASE: assert property (ack9 && adr |-> !host_sda_oe)
        else $error("host holds sda in address ack");
    AST_FOREIGN: assert property (ack9 && adr && sh_reg[7:1] != {TYPE_CODE, SEL} |-> sda)
        else $error("foreign address acked");
    AST_RD_QUIET: assert property (rise && rd_reg && !adr
        && bit_reg != 4'h0 && bit_reg != 4'h8 |-> !host_sda_oe)
        else $error("host drives during read data");
    AST_ACK_SLOT: assert property (ack9 && rd_reg && !adr |-> !dev_sda_oe)
        else $error("device holds sda in host ack");
    AST_NACK_END: assert property (ack9 && rd_reg && !adr && sda |=> !dev_sda_oe [*8])
        else $error("device drives after nack");
    COV_RD: cover property (ack9 && adr && rd_reg && !sda);
    COV_MORE: cover property (ack9 && !adr && rd_reg && !sda);
    COV_REFUSE: cover property (ack9 && adr && sda);
endmodule : sev_link_properties
`default_nettype wire

// *** serial_eeprom_i2c_read_path_tb_top.sv ***
// Bench joining both read-link ends
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_i2c_read_path_tb_top;
    logic clk = 0, lclk = 0, rst = 1, cv = 0, csel = 0, rdy = 0, busy = 0, ld = 0, stall = 0;
    logic [15:0] ca = 0;
    logic [7:0] cl = 1, ldd = 0, rdd;
    logic [2:0] cs = 3'h5;
    logic [12:0] lda = 0, cur;
    logic crdy, rv, nk, dn, bs;
    int mismatches = 0, n_checks = 0, seed = 59, ptr = 0, nsent = 0;
    logic [7:0] q[$];
    sev_i2c_if bus ();
    sev_dev_end sev_dev_end_i (.i_link_clk(lclk), .i_link_rst(rst), .i_select_pin_bit0(1'b1),
        .i_select_pin_bit1(1'b0), .i_select_pin_bit2(1'b1), .i_wr_busy(busy), .i_ld_en(ld),
        .i_ld_addr(lda), .i_ld_data(ldd), .o_cur_addr(cur), .o_byte_sent(bs), .bus(bus));
    sev_host_end #(.QUARTER(32)) sev_host_end_i (.i_core_clk(clk), .i_rst(rst),
        .i_cmd_valid(cv), .o_cmd_ready(crdy), .i_cmd_selective(csel), .i_cmd_addr(ca),
        .i_cmd_len(cl), .i_cmd_select(cs), .o_rd_valid(rv), .i_rd_ready(rdy),
        .o_rd_data(rdd), .o_nack(nk), .o_done(dn), .bus(bus));
    sev_link_properties #(.SEL(3'h5)) sev_link_properties_i (.i_core_clk(clk), .i_rst(rst),
        .scl(bus.scl), .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda));
    initial forever #2.5 clk = ~clk;
    initial begin
        #7;
        forever #15 lclk = ~lclk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // Random back-pressure on the read FIFO
    always @(negedge clk) rdy <= !stall && $random(seed) % 2 != 0;
    // Device-side count of bytes handed to the wire
    always @(posedge lclk) if (bs === 1'b1) nsent++;
    always @(posedge clk) if (rv && rdy) chk({8'h00, rdd}, {8'h00, q.pop_front()});
    // Preload what the model expects, issue one command, wait for its end
    task automatic run(input logic s, input int a, input int n, input logic [2:0] p,
                       input logic b, input logic e);
        logic seen;
        int k, s0;
        seen = 0;
        s0 = nsent;
        if (s) ptr = a;
        for (k = 0; k < n && !e; k++) begin
            @(negedge lclk);
            ld = 1;
            lda = ptr[12:0];
            ldd = 8'($random(seed));
            q.push_back(ldd);
            ptr = (ptr + 1) % 8192;
        end
        @(negedge lclk);
        ld = 0;
        busy = b;
        @(negedge clk);
        cv = 1;
        csel = s;
        ca = a[15:0];
        cl = n[7:0];
        cs = p;
        @(posedge clk);
        chk({15'h0, crdy}, 16'h1);
        @(negedge clk);
        cv = 0;
        for (k = 0; k < 40000 && dn !== 1'b1; k++) begin
            @(posedge clk);
            #1 seen |= nk === 1'b1;
        end
        if (k == 40000) begin
            mismatches++;
            $display("MISMATCH %0t timeout", $time);
            give_verdict;
        end
        repeat (4) @(negedge lclk);
        chk({15'h0, seen}, {15'h0, e});
        chk({3'h0, cur}, ptr[15:0]);
        chk(16'(nsent - s0), e ? 16'h0 : 16'(n));
        busy = 0;
    endtask : run
    initial begin
        repeat (16) @(negedge clk);
        rst = 0;
        run(1, $random(seed) & 8191, 3, 3'h5, 0, 0);
        run(0, 0, 1, 3'h5, 0, 0);
        run(0, 0, 1, 3'h2, 0, 1);
        run(0, 0, 1, 3'h5, 1, 1);
        run(1, 8190, 4, 3'h5, 0, 0);
        fork
            run(0, 0, 12, 3'h5, 0, 0);
            begin
                stall = 1;
                repeat (14000) @(posedge clk);
                chk({15'h0, rv}, 16'h1);
                stall = 0;
            end
        join
        repeat (200) @(posedge clk);
        chk(16'(q.size()), 16'h0);
        give_verdict;
    end
endmodule : serial_eeprom_i2c_read_path_tb_top
`default_nettype wire
